// ===== cnsu_pkg.sv
// Constants and types of the node setup and status block
package cnsu_pkg;
  // ==========================================
  // Clock and timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned CFG_TIMEOUT_S  = 30;
  localparam int unsigned CFG_TIMEOUT_CYC = CFG_TIMEOUT_S * CLK_HZ;
  localparam int unsigned FLASH_MS       = 200;
  localparam int unsigned FLASH_CYC      = FLASH_MS * (CLK_HZ / 1000);
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_STATUS   = 8'h04;
  localparam logic [7:0] OFS_SETUP    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR  = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN   = 8'h14;
  // ==========================================
  // Field positions
  localparam int CTRL_CFG_DONE  = 0;
  localparam int ST_FORCED      = 2;
  localparam int ST_BUS_EN      = 3;
  localparam int ST_RATE_OK     = 4;
  localparam int ST_ADDR_OK     = 5;
  localparam int SU_ADDR_LSB    = 16;
  localparam int IRQ_W          = 4;
  localparam int IRQ_TIMEOUT    = 0;
  localparam int IRQ_BUS_OFF    = 1;
  localparam int IRQ_HBEAT      = 2;
  localparam int IRQ_SYNC       = 3;
  localparam logic [IRQ_W-1:0] IRQ_EN_RST = 4'h0;
  // ==========================================
  // Switch decoding
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [6:0] TENS_WEIGHT = 7'h0A;
  localparam logic [10:0] RATE_TBL [0:9] = '{
    11'h000, 11'h00A, 11'h014, 11'h032, 11'h07D,
    11'h0FA, 11'h1F4, 11'h320, 11'h3E8, 11'h000};
  // ==========================================
  // Indicator patterns, length in 200 ms steps
  typedef enum logic [2:0] {
    PAT_OFF, PAT_ON, PAT_BLINK, PAT_FLASH1, PAT_FLASH2, PAT_FLASH3
  } cnsu_pat_type;
  localparam logic [3:0] LEN_BLINK  = 4'h2;
  localparam logic [3:0] LEN_FLASH1 = 4'h6;
  localparam logic [3:0] LEN_FLASH2 = 4'h8;
  localparam logic [3:0] LEN_FLASH3 = 4'hA;
  localparam logic [3:0] LEN_STEADY = 4'h1;
  typedef enum logic [1:0] {
    NMT_PREOP, NMT_OPER, NMT_STOP
  } cnsu_nmt_type;
endpackage

// ===== cnsu_node.sv
// Node setup, start-up timeout and status indicators
// Notes on behaviour
// - Rate switch 1..8 maps 10k..1M, 0/9 invalid
// - Rate sampled at start-up only
// - Address is tens times ten plus ones
// - Configure and start bus without command
// - No configuration in 30 s: join, show running
// - Timeout sends external error emergency
// - Run indicator follows node state
// - Error indicator on while bus-off
// - Single flash at error warning level
// - Double flash on heartbeat failure
// - Triple flash on missing sync
//
// Decided for this implementation: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ns
module cnsu_node
  import cnsu_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = CFG_TIMEOUT_CYC,
  parameter int unsigned STEP_CYC    = FLASH_CYC
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  output logic              int_o,
  input  wire logic [3:0]   rate_select_switch,
  input  wire logic [3:0]   tens_address_switch,
  input  wire logic [3:0]   ones_address_switch,
  input  wire logic         base_cfg_valid,
  input  cnsu_nmt_type      nmt_state,
  input  wire logic         bus_connected,
  input  wire logic         module_error,
  input  wire logic         can_bus_off,
  input  wire logic         can_warning,
  input  wire logic         heartbeat_fail,
  input  wire logic         sync_missing,
  output logic [10:0]       rate_kbps,
  output logic              rate_valid,
  output logic [6:0]        node_address,
  output logic              address_valid,
  output logic              bus_enable,
  output logic              emcy_ext_error,
  output logic              run_led,
  output logic              err_led
);
  // ==========================================
  // Parameter checks
  if (TIMEOUT_CYC < 1 || STEP_CYC < 1) begin : g_chk
    $error("cnsu_node: counts must be at least one");
  end

  typedef enum logic [1:0] {S_LATCH, S_WAIT, S_RUN} cnsu_st_type;

  function automatic logic [3:0] pat_len(input cnsu_pat_type p);
    unique case (p)
      PAT_BLINK:  pat_len = LEN_BLINK;
      PAT_FLASH1: pat_len = LEN_FLASH1;
      PAT_FLASH2: pat_len = LEN_FLASH2;
      PAT_FLASH3: pat_len = LEN_FLASH3;
      PAT_OFF,
      PAT_ON:     pat_len = LEN_STEADY;
      default:    pat_len = LEN_STEADY;
    endcase
  endfunction

  function automatic logic pat_lit(input cnsu_pat_type p,
                                   input logic [3:0] s);
    unique case (p)
      PAT_ON:     pat_lit = 1'b1;
      PAT_BLINK:  pat_lit = (s == 4'h0);
      PAT_FLASH1: pat_lit = (s == 4'h0);
      PAT_FLASH2: pat_lit = !s[0] && (s < 4'h3);
      PAT_FLASH3: pat_lit = !s[0] && (s < 4'h5);
      PAT_OFF:    pat_lit = 1'b0;
      default:    pat_lit = 1'b0;
    endcase
  endfunction

  // ==========================================
  // Wishbone slave, one wait state
  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_en_reg;
  logic [31:0]      rdata;
  wire              req      = wb_cyc_i && wb_stb_i;
  wire              wr_take  = req && wb_we_i && ack_reg;
  wire              wr_low   = wr_take && wb_sel_i[0];
  wire              cfg_wr   = wr_low && (wb_adr_i == OFS_CTRL);
  wire              clr_wr   = wr_low && (wb_adr_i == OFS_IRQ_CLR);
  wire              en_wr    = wr_low && (wb_adr_i == OFS_IRQ_EN);
  wire [IRQ_W-1:0]  irq_clr  = clr_wr ? wb_dat_i[IRQ_W-1:0] : '0;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req && !ack_reg;
      if (req && !ack_reg) begin
        dat_reg <= rdata;
      end
    end
  end
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // ==========================================
  // Start-up sequencer
  cnsu_st_type st_reg;
  cnsu_st_type st_next;
  logic [31:0] tmo_reg;
  logic        forced_reg;
  logic        emcy_reg;
  logic [3:0]  rate_sw_reg;
  logic [3:0]  tens_reg;
  logic [3:0]  ones_reg;
  wire         cfg_in   = base_cfg_valid || (cfg_wr && wb_dat_i[CTRL_CFG_DONE]);
  wire         tmo_hit  = (st_reg == S_WAIT) && !cfg_in &&
                          (tmo_reg == TIMEOUT_CYC - 1);

  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      S_LATCH: st_next = S_WAIT;
      // Start on configuration
      // automatic start
      S_WAIT:  if (cfg_in || tmo_hit) begin
        st_next = S_RUN;
      end
      S_RUN:   st_next = S_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg      <= S_LATCH;
      tmo_reg     <= 32'h0000_0000;
      forced_reg  <= 1'b0;
      emcy_reg    <= 1'b0;
      rate_sw_reg <= 4'h0;
      tens_reg    <= 4'h0;
      ones_reg    <= 4'h0;
    end else begin
      st_reg   <= st_next;
      emcy_reg <= tmo_hit;
      if (st_reg == S_LATCH) begin
        rate_sw_reg <= rate_select_switch;
        tens_reg    <= tens_address_switch;
        ones_reg    <= ones_address_switch;
      end
      if (st_reg == S_WAIT) begin
        tmo_reg <= tmo_reg + 32'h0000_0001;
      end
      if (tmo_hit) begin
        forced_reg <= 1'b1;
      end
    end
  end

  assign rate_valid    = (rate_sw_reg != 4'h0) && (rate_sw_reg <= 4'h8);
  assign rate_kbps     = rate_valid ? RATE_TBL[rate_sw_reg] : 11'h000;
  assign node_address  = 7'(tens_reg) * TENS_WEIGHT + 7'(ones_reg);
  assign address_valid = (tens_reg <= DIGIT_MAX) && (ones_reg <= DIGIT_MAX);
  assign bus_enable    = (st_reg == S_RUN);
  assign emcy_ext_error = emcy_reg;

  // ==========================================
  // Interrupt status, set wins over clear
  logic bus_off_d_reg;
  logic hbeat_d_reg;
  logic sync_d_reg;
  wire [IRQ_W-1:0] irq_ev = {sync_missing && !sync_d_reg,
                             heartbeat_fail && !hbeat_d_reg,
                             can_bus_off && !bus_off_d_reg,
                             tmo_hit};

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_stat_reg  <= '0;
      irq_en_reg    <= IRQ_EN_RST;
      bus_off_d_reg <= 1'b0;
      hbeat_d_reg   <= 1'b0;
      sync_d_reg    <= 1'b0;
    end else begin
      irq_stat_reg  <= (irq_stat_reg & ~irq_clr) | irq_ev;
      bus_off_d_reg <= can_bus_off;
      hbeat_d_reg   <= heartbeat_fail;
      sync_d_reg    <= sync_missing;
      if (en_wr) begin
        irq_en_reg <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end
  assign int_o = |(irq_stat_reg & irq_en_reg);

  // Unmapped and write-only offsets read as zero
  assign rdata =
    (wb_adr_i == OFS_STATUS) ?
      32'({address_valid, rate_valid, bus_enable, forced_reg,
           2'(st_reg)}) :
    (wb_adr_i == OFS_SETUP) ?
      32'({node_address, rate_sw_reg, 1'b0, rate_kbps}) :
    (wb_adr_i == OFS_IRQ_STAT) ? 32'(irq_stat_reg) :
    (wb_adr_i == OFS_IRQ_EN)   ? 32'(irq_en_reg) : 32'h0000_0000;

  // ==========================================
  // Indicator pattern selection
  cnsu_pat_type run_pat;
  cnsu_pat_type err_pat;
  assign run_pat =
    (!bus_enable || !bus_connected || module_error) ? PAT_OFF :
    (forced_reg || nmt_state == NMT_OPER) ? PAT_ON :
    (nmt_state == NMT_STOP) ? PAT_FLASH1 : PAT_BLINK;
  assign err_pat =
    can_bus_off    ? PAT_ON :
    sync_missing   ? PAT_FLASH3 :
    heartbeat_fail ? PAT_FLASH2 :
    can_warning    ? PAT_FLASH1 : PAT_OFF;

  // ==========================================
  // Step timer shared by both indicators
  logic [31:0] tick_reg;
  wire         tick = (tick_reg == STEP_CYC - 1);
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg <= 32'h0000_0000;
    end else begin
      tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
    end
  end

  // Pattern restarts on change so a new state shows from its first step
  cnsu_pat_type pats [2];
  logic         leds [2];
  assign pats[0] = run_pat;
  assign pats[1] = err_pat;
  for (genvar i = 0; i < 2; i++) begin : g_led
    cnsu_pat_type pat_d_reg;
    logic [3:0]   step_reg;
    logic         led_reg;
    wire          chg  = (pats[i] != pat_d_reg);
    wire [3:0]    nstp = (step_reg + 4'h1 >= pat_len(pats[i])) ?
                         4'h0 : step_reg + 4'h1;
    wire [3:0]    cur  = chg ? 4'h0 : (tick ? nstp : step_reg);
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        pat_d_reg <= PAT_OFF;
        step_reg  <= 4'h0;
        led_reg   <= 1'b0;
      end else begin
        pat_d_reg <= pats[i];
        step_reg  <= cur;
        led_reg   <= pat_lit(pats[i], cur);
      end
    end
    assign leds[i] = led_reg;
  end
  assign run_led = leds[0];
  assign err_led = leds[1];

  // ==========================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_rate_fixed;
    (st_reg != S_LATCH) |=> $stable(rate_kbps);
  endproperty
  a_rate_fixed: assert property (p_rate_fixed)
    else $error("rate changed while running");

  property p_rate_map;
    (st_reg != S_LATCH && rate_sw_reg == 4'h3) |-> rate_kbps == 11'h032;
  endproperty
  a_rate_map: assert property (p_rate_map)
    else $error("rate setting 3 not 50 kbit/s");

  property p_rate_bad;
    (rate_sw_reg == 4'h9 || rate_sw_reg == 4'h0) |-> !rate_valid;
  endproperty
  a_rate_bad: assert property (p_rate_bad)
    else $error("invalid rate accepted");

  property p_addr;
    (st_reg == S_WAIT && $past(st_reg) == S_LATCH) |->
      node_address == 7'($past(tens_address_switch)) * TENS_WEIGHT
                      + 7'($past(ones_address_switch));
  endproperty
  a_addr: assert property (p_addr)
    else $error("node address wrong");

  property p_start;
    (st_reg == S_WAIT && base_cfg_valid) |=> bus_enable && !forced_reg;
  endproperty
  a_start: assert property (p_start)
    else $error("no start on configuration");

  property p_timeout;
    tmo_hit |=> bus_enable && forced_reg && emcy_ext_error
                ##1 !emcy_ext_error;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("timeout handling wrong");

  property p_run_off;
    (!bus_connected || module_error) |-> run_pat == PAT_OFF;
  endproperty
  a_run_off: assert property (p_run_off)
    else $error("run indicator not off");

  property p_busoff;
    can_bus_off [*2] |=> err_led;
  endproperty
  a_busoff: assert property (p_busoff)
    else $error("bus-off indicator not on");

  property p_err_pat;
    !can_bus_off && !sync_missing |->
      err_pat == (heartbeat_fail ? PAT_FLASH2 :
                  can_warning ? PAT_FLASH1 : PAT_OFF);
  endproperty
  a_err_pat: assert property (p_err_pat)
    else $error("error pattern wrong");

  property p_sync;
    (!can_bus_off && sync_missing) |-> err_pat == PAT_FLASH3;
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync pattern wrong");

  property p_err_clean;
    (err_pat == PAT_OFF) [*2] |=> !err_led;
  endproperty
  a_err_clean: assert property (p_err_clean)
    else $error("error indicator lit when clean");

  c_timeout: cover property (tmo_hit);
  c_cfg: cover property (st_reg == S_WAIT && cfg_in);
  c_irq: cover property (int_o);
  c_flash: cover property (err_pat == PAT_FLASH2 && err_led);
endmodule // cnsu_node

// ===== cnsu_master_model.sv
// Fieldbus master model facing the node block
`timescale 1ns/1ns
module cnsu_master_model
  import cnsu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       bus_enable,
  input  wire logic       emcy_ext_error,
  input  wire logic [1:0] cmd_state,
  input  wire logic [5:0] cmd_lv,
  output cnsu_nmt_type    nmt_state,
  output logic [5:0]      lv,
  output logic [7:0]      emcy_cnt
);
  // ==========================================
  // State commands
  // No state command reaches a node that has not joined
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nmt_state <= NMT_PREOP;
      lv        <= 6'h00;
      emcy_cnt  <= 8'h00;
    end else begin
      nmt_state <= bus_enable ? cnsu_nmt_type'(cmd_state) : NMT_PREOP;
      lv        <= cmd_lv;
      emcy_cnt  <= emcy_cnt + {7'h00, emcy_ext_error};
    end
  end
endmodule // cnsu_master_model

// ===== test_canopen_node_setup_status.sv
// Self-checking bench of the node setup and status block
`timescale 1ns/1ns
module test_canopen_node_setup_status
  import cnsu_pkg::*;
;
  // ==========================================
  // Signals
  localparam int TMO = 50;
  typedef struct packed {
    logic [3:0]   rs, tn, on;
    cnsu_nmt_type st;
    logic [5:0]   lv;
    logic [10:0]  kb;
    logic [6:0]   ad;
    logic [9:0]   rl, el;
  } cnsu_row_type;
  // Full 480-cycle windows make lit counts phase independent
  localparam cnsu_row_type ROWS [0:9] = '{
    '{4'h0,4'h0,4'h0,NMT_OPER,6'h10,11'h000,7'h00,10'h1E0,10'h000},
    '{4'h1,4'h9,4'h9,NMT_STOP,6'h11,11'h00A,7'h63,10'h050,10'h1E0},
    '{4'h2,4'h3,4'h6,NMT_PREOP,6'h12,11'h014,7'h24,10'h0F0,10'h050},
    '{4'h3,4'h1,4'h2,NMT_OPER,6'h14,11'h032,7'h0C,10'h1E0,10'h078},
    '{4'h4,4'h5,4'h0,NMT_OPER,6'h18,11'h07D,7'h32,10'h1E0,10'h090},
    '{4'h5,4'h0,4'h7,NMT_OPER,6'h1F,11'h0FA,7'h07,10'h1E0,10'h1E0},
    '{4'h6,4'h4,4'h4,NMT_OPER,6'h1E,11'h1F4,7'h2C,10'h1E0,10'h090},
    '{4'h7,4'h8,4'h1,NMT_OPER,6'h16,11'h320,7'h51,10'h1E0,10'h078},
    '{4'h8,4'h2,4'h2,NMT_OPER,6'h00,11'h3E8,7'h16,10'h000,10'h000},
    '{4'h9,4'h6,4'h6,NMT_OPER,6'h30,11'h000,7'h42,10'h000,10'h000}};
  logic         clk, arst_n = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic         wb_we_i = 1'b0, base_cfg_valid = 1'b0;
  logic [7:0]   wb_adr_i = 8'h00, emcy_cnt;
  logic [3:0]   wb_sel_i = 4'hF;
  logic [31:0]  wb_dat_i = 32'h0, wb_dat_o, q;
  logic         wb_ack_o, int_o, rate_valid, address_valid;
  logic         bus_enable, emcy_ext_error, run_led, err_led;
  logic [3:0]   rate_select_switch = 4'h0;
  logic [3:0]   tens_address_switch = 4'h0, ones_address_switch = 4'h0;
  logic [1:0]   cst = 2'h0;
  logic [5:0]   clv = 6'h00, lv;
  logic [10:0]  rate_kbps;
  logic [6:0]   node_address;
  logic [9:0]   nr, ne;
  logic         module_error, bus_connected, sync_missing;
  logic         heartbeat_fail, can_warning, can_bus_off;
  cnsu_nmt_type nmt_state;
  cnsu_row_type r;
  int           num_errors = 0, checks = 0, n;
  assign {module_error, bus_connected, sync_missing, heartbeat_fail,
          can_warning, can_bus_off} = lv;
  cnsu_node #(.TIMEOUT_CYC(TMO), .STEP_CYC(4)) cnsu_node_inst (
    .clk, .arst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .int_o, .rate_select_switch,
    .tens_address_switch, .ones_address_switch, .base_cfg_valid,
    .nmt_state, .bus_connected, .module_error, .can_bus_off, .can_warning,
    .heartbeat_fail, .sync_missing, .rate_kbps, .rate_valid, .node_address,
    .address_valid, .bus_enable, .emcy_ext_error, .run_led, .err_led);
  cnsu_master_model cnsu_master_model_inst (
    .clk, .arst_n, .bus_enable, .emcy_ext_error, .cmd_state(cst),
    .cmd_lv(clv), .nmt_state, .lv, .emcy_cnt);
  // ==========================================
  // Tasks
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reset also checks that outputs stay quiet while held
  task automatic do_reset;
    arst_n <= 1'b0;
    tick(5);
    cmp({bus_enable, run_led, err_led, int_o, wb_ack_o}, 0);
    arst_n <= 1'b1;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] rd);
    int k;
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    for (k = 0; k < 20 && wb_ack_o !== 1'b1; k++)
      @(posedge clk);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    cmp(k < 20, 1);
    if (k == 20)
      finish_test;
  endtask
  task automatic lit(output logic [9:0] rc, ec);
    rc = 0;
    ec = 0;
    repeat (480) begin
      @(posedge clk);
      rc += run_led;
      ec += err_led;
    end
  endtask
  // ==========================================
  // Stimulus
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    tick(20000);
    num_errors++;
    finish_test;
  end
  initial begin
    foreach (ROWS[i]) begin
      r = ROWS[i];
      {rate_select_switch, tens_address_switch, ones_address_switch,
       cst, clv} <= r[57:38];
      do_reset;
      tick(3);
      base_cfg_valid <= 1'b1;
      tick(1);
      base_cfg_valid <= 1'b0;
      tick(3);
      cmp(bus_enable, 1);
      cmp(rate_kbps, r.kb);
      cmp(rate_valid, r.rs inside {[4'h1:4'h8]});
      cmp({address_valid, node_address}, {1'b1, r.ad});
      lit(nr, ne);
      cmp(nr, r.rl);
      cmp(ne, r.el);
      cmp(emcy_cnt, 0);
      $display("row %0d done", i);
    end
    // No configuration: forced join after the timeout
    {rate_select_switch, tens_address_switch, ones_address_switch,
     cst, clv} <= {12'h512, 2'h0, 6'h10};
    do_reset;
    for (n = 0; n < 200 && bus_enable !== 1'b1; n++)
      tick(1);
    cmp(n >= TMO && n <= TMO + 6, 1);
    if (n == 200)
      finish_test;
    tick(2);
    cmp(emcy_cnt, 1);
    lit(nr, ne);
    cmp(nr, 10'h1E0);
    wb(1'b0, OFS_STATUS, 32'h0, q);
    cmp(q[3:2], 2'h3);
    wb(1'b0, OFS_IRQ_STAT, 32'h0, q);
    cmp({int_o, q[3:0]}, 5'h01);
    wb(1'b1, OFS_IRQ_EN, 32'h1, q);
    tick(1);
    cmp(int_o, 1);
    wb(1'b1, OFS_IRQ_CLR, 32'h1, q);
    clv <= 6'h11;
    tick(3);
    cmp(int_o, 0);
    wb(1'b0, OFS_IRQ_STAT, 32'h0, q);
    cmp(q[3:0], 4'h2);
    wb(1'b0, 8'hFC, 32'h0, q);
    cmp(q, 0);
    $display("timeout case done");
    // Rate switch moved while running
    rate_select_switch <= 4'h1;
    tick(5);
    cmp(rate_kbps, 11'h0FA);
    wb(1'b0, OFS_SETUP, 32'h0, q);
    cmp(q[22:12], {7'h0C, 4'h5});
    $display("switch case done");
    // Start by register write, tens digit out of range
    {rate_select_switch, tens_address_switch, ones_address_switch,
     cst, clv} <= {12'h3A4, 2'h1, 6'h10};
    do_reset;
    wb(1'b1, OFS_CTRL, 32'h1, q);
    tick(1);
    cmp(bus_enable, 1);
    cmp({address_valid, rate_kbps}, {1'b0, 11'h032});
    wb(1'b0, OFS_STATUS, 32'h0, q);
    cmp(q[5:0], 6'h1A);
    lit(nr, ne);
    cmp({nr, emcy_cnt}, {10'h1E0, 8'h00});
    $display("register start case done");
    finish_test;
  end
endmodule // test_canopen_node_setup_status
